// *** rtl/rtc_log_pkg.sv ***
// Purpose: Shared constants and record types for the run-time clock and fault logger
// Assumes: core_clk at 200 MHz
// Notes:   Voltages are in millivolts, 12 bits wide

package rtc_log_pkg;

    // ******************************
    // Timing
    // ******************************
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned MS_PER_S    = 1000;
    localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
    localparam int unsigned PEAK_WIN_S  = 30;
    localparam int unsigned PEAK_WIN_MS = PEAK_WIN_S * MS_PER_S;
    localparam logic [31:0] MS_PER_DAY  = 32'h0526_5C00;

    // ******************************
    // Widths and thresholds
    // ******************************
    localparam int unsigned RAIL_W      = 4;
    localparam int unsigned FTYPE_W     = 4;
    localparam int unsigned VOLT_W      = 12;
    localparam logic [11:0] BROWNOUT_MV = 12'hB54;
    localparam int unsigned DEF_RAILS   = 12;
    localparam int unsigned DEF_FAULTS  = 12;

    // ******************************
    // Record types
    // ******************************
    typedef enum logic [1:0] {REC_CLOCK, REC_RESETS, REC_PEAK, REC_FAULT} rec_kind_e;

    typedef struct packed {
        logic [31:0] days;
        logic [31:0] ms;
    } rt_time_s;

    typedef struct packed {
        logic [RAIL_W-1:0]  rail;
        logic [FTYPE_W-1:0] ftype;
        logic [VOLT_W-1:0]  volt;
    } fault_in_s;

    // Reset count travels in time_v.ms for REC_RESETS
    typedef struct packed {
        rec_kind_e          kind;
        logic [RAIL_W-1:0]  rail;
        logic [FTYPE_W-1:0] ftype;
        logic [VOLT_W-1:0]  volt;
        rt_time_s           time_v;
    } flash_rec_s;

endpackage

// *** rtl/rtc_fault_logger.sv ***
// Purpose: Run-time clock, fault/peak/reset-count logging to flash, brownout buffering
// Assumes: All inputs synchronous to core_clk; nvm_restore_valid pulses once after reset
// Notes:   Flash writes wait for the brownout dump while brownout mode is on
// Contract
// R1: Clock is two 32-bit unsigned counts, milliseconds and days.
// R2: Commit command writes current clock value to nonvolatile memory.
// R3: Host may write the clock; counting continues from written value.
// R4: Host converts calendar time to days and ms and back itself.
// R5: Without persistence the clock restarts from zero after every reset.
// R6: Persistent clock survives restarts and advances only after boot completes.
// R7: In local-time use, host reloads real time after every restart.
// R8: Each fault record is stamped with the current clock value.
// R9: Fault record holds rail, fault type, elapsed time and last voltage.
// R10: Several fault records kept and readable back by the host.
// R11: Nonvolatile reset count kept; host command clears it.
// R12: Peak exceedance opens 30 s window; only window maximum goes to flash.
// R13: Brownout mode is off unless host configuration enables it.
// R14: Supply below 2.9 V flags a brownout event.
// R15: Brownout mode holds all log data in RAM, no flash logging.
// R16: Brownout event copies buffered log data and clock to flash.
// R17: Brownout mode performs no flash writes in normal operation.
// R18: Clock returns to zero without brownout mode, persists with it.
// R19: At 86,400,000 ms the ms count clears and days increment.

`timescale 1ns/1ps

module rtc_fault_logger
    import rtc_log_pkg::*;
#(
    parameter int unsigned N_RAILS     = DEF_RAILS,
    parameter int unsigned FAULT_DEPTH = DEF_FAULTS,
    parameter int unsigned CYC_MS      = CYC_PER_MS,
    parameter int unsigned WIN_MS      = PEAK_WIN_MS
) (
    input  wire logic                       core_clk,           // System clock
    input  wire logic                       arst_n,             // Async reset, active low
    input  wire logic                       boot_done,          // High once normal operation starts
    input  wire logic                       rt_wr_valid,        // Host clock write strobe
    input  wire rt_time_s                   rt_wr_time,         // Host clock write value
    input  wire logic                       commit_cmd,         // Commit-config-to-nvm strobe
    input  wire logic                       clr_resets_cmd,     // Clear reset count strobe
    input  wire logic                       misc_bo_en,         // Brownout mode enable from config
    input  wire logic                       nvm_restore_valid,  // Saved values from flash, once
    input  wire rt_time_s                   nvm_restore_time,   // Saved clock
    input  wire logic [31:0]                nvm_restore_resets, // Saved reset count
    input  wire logic                       fault_valid,        // Fault event strobe
    input  wire fault_in_s                  fault_in,           // Fault rail, type, voltage
    input  wire logic                       meas_valid,         // Rail measurement strobe
    input  wire logic [RAIL_W-1:0]          meas_rail,          // Measured rail
    input  wire logic [VOLT_W-1:0]          meas_volt,          // Measured voltage, mV
    input  wire logic [VOLT_W-1:0]          vcc_mv,             // Supply voltage, mV
    input  wire logic [$clog2(FAULT_DEPTH)-1:0] rd_idx,         // Fault readback index
    input  wire logic                       flash_wr_ready,     // Flash accepts record
    output rt_time_s                        rt_time,            // Current run-time clock
    output logic [31:0]                     reset_count,        // Device reset count
    output logic                            brownout_flag,      // Supply below threshold
    output flash_rec_s                      rd_rec,             // Fault record at rd_idx
    output logic [$clog2(FAULT_DEPTH+1)-1:0] fault_count,       // Stored fault records
    output logic                            flash_wr_valid,     // Record offered to flash
    output flash_rec_s                      flash_wr_rec        // Record to write
);

    localparam int unsigned PRE_W = $clog2(CYC_MS);
    localparam int unsigned WIN_W = $clog2(WIN_MS);
    localparam int unsigned IDX_W = $clog2(FAULT_DEPTH);
    localparam int unsigned FC_W  = $clog2(FAULT_DEPTH+1);

    if (N_RAILS < 1 || N_RAILS > (1 << RAIL_W) || FAULT_DEPTH < 2 || CYC_MS < 2 || WIN_MS < 2) begin : g_chk
        $error("rtc_fault_logger: unsupported parameter values");
    end

    typedef enum {ST_IDLE, ST_WRITE} st_e;

    // ******************************
    // Run-time clock
    // ******************************
    rt_time_s           time_r,  time_nxt;
    logic [PRE_W-1:0]   pre_r,   pre_nxt;
    logic               restored_r, restored_nxt, bo_en_r;
    logic               tick;
    logic               take_restore;

    assign tick         = boot_done && (pre_r == PRE_W'(CYC_MS - 1));
    assign take_restore = nvm_restore_valid && !restored_r;

    always_comb begin
        time_nxt     = time_r;
        pre_nxt      = pre_r;
        restored_nxt = restored_r || nvm_restore_valid;
        pre_nxt      = boot_done ? (tick ? '0 : pre_r + 1'b1) : pre_r;  // R6
        if (rt_wr_valid) begin
            time_nxt = rt_wr_time;                                       // R3
            pre_nxt  = '0;
        end else if (take_restore && bo_en_r) begin
            time_nxt = nvm_restore_time;                                 // R18
        end else if (tick) begin
            if (time_r.ms == MS_PER_DAY - 32'h1) begin
                time_nxt.ms   = '0;                                      // R19
                time_nxt.days = time_r.days + 32'h1;                     // R1
            end else begin
                time_nxt.ms = time_r.ms + 32'h1;                         // R1
            end
        end
    end

    // Reset clears the clock; only a restore in brownout mode brings it back
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            time_r     <= '0;                                            // R5
            pre_r      <= '0;
            restored_r <= 1'b0;
        end else begin
            time_r     <= time_nxt;
            pre_r      <= pre_nxt;
            restored_r <= restored_nxt;
        end
    end

    // ******************************
    // Logger state
    // ******************************
    st_e                st_r, st_nxt;
    logic               vcc_low_r, dump_r, dump_nxt;
    logic               clk_pend_r, clk_pend_nxt, rst_pend_r, rst_pend_nxt;
    logic [31:0]        rcnt_r, rcnt_nxt;
    logic [VOLT_W-1:0]  peak_r [N_RAILS], peak_nxt [N_RAILS];
    logic [VOLT_W-1:0]  wmax_r [N_RAILS], wmax_nxt [N_RAILS];
    logic [WIN_W-1:0]   wms_r [N_RAILS], wms_nxt [N_RAILS];
    logic [N_RAILS-1:0] won_r, won_nxt, dirty_r, dirty_nxt;
    flash_rec_s         fbuf_r [FAULT_DEPTH];
    logic [FC_W-1:0]    fcnt_r, fcnt_nxt, flush_r, flush_nxt;
    flash_rec_s         out_r, out_nxt;
    logic               outv_r, outv_nxt;
    flash_rec_s         rd_r;
    logic               vcc_low, go, fault_take;

    assign vcc_low    = vcc_mv < BROWNOUT_MV;                            // R14
    assign go         = !bo_en_r || dump_r;                              // R17
    assign fault_take = fault_valid && (fcnt_r < FC_W'(FAULT_DEPTH));

    always_comb begin
        st_nxt       = st_r;
        dump_nxt     = dump_r;
        clk_pend_nxt = clk_pend_r;
        rst_pend_nxt = rst_pend_r;
        rcnt_nxt     = rcnt_r;
        peak_nxt     = peak_r;
        wmax_nxt     = wmax_r;
        wms_nxt      = wms_r;
        won_nxt      = won_r;
        dirty_nxt    = dirty_r;
        fcnt_nxt     = fcnt_r;
        flush_nxt    = flush_r;
        out_nxt      = out_r;
        outv_nxt     = outv_r;
        // Drain engine: clears first so that events below win
        case (st_r)
            ST_IDLE: begin
                if (go) begin
                    if (clk_pend_r) begin
                        clk_pend_nxt       = 1'b0;
                        out_nxt            = '0;
                        out_nxt.kind       = REC_CLOCK;
                        out_nxt.time_v     = time_r;                     // R2
                        outv_nxt           = 1'b1;
                        st_nxt             = ST_WRITE;
                    end else if (rst_pend_r) begin
                        rst_pend_nxt       = 1'b0;
                        out_nxt            = '0;
                        out_nxt.kind       = REC_RESETS;
                        out_nxt.time_v.ms  = rcnt_r;                     // R11
                        outv_nxt           = 1'b1;
                        st_nxt             = ST_WRITE;
                    end else if (|dirty_r) begin
                        out_nxt      = '0;
                        out_nxt.kind = REC_PEAK;
                        for (int i = N_RAILS - 1; i >= 0; i--) begin
                            if (dirty_r[i]) begin
                                out_nxt.rail = RAIL_W'(i);
                                out_nxt.volt = peak_r[i];                // R12
                            end
                        end
                        dirty_nxt[out_nxt.rail] = 1'b0;
                        outv_nxt = 1'b1;
                        st_nxt   = ST_WRITE;
                    end else if (flush_r < fcnt_r) begin
                        out_nxt   = fbuf_r[flush_r[IDX_W-1:0]];          // R16
                        flush_nxt = flush_r + 1'b1;
                        outv_nxt  = 1'b1;
                        st_nxt    = ST_WRITE;
                    end else begin
                        dump_nxt = 1'b0;
                    end
                end
            end
            ST_WRITE: begin
                if (flash_wr_ready) begin
                    outv_nxt = 1'b0;
                    st_nxt   = ST_IDLE;
                end
            end
            default: begin
                st_nxt   = ST_IDLE;
                outv_nxt = 1'b0;
            end
        endcase
        // Peak windows: only the window maximum reaches flash
        for (int i = 0; i < N_RAILS; i++) begin
            if (won_r[i]) begin
                if (meas_valid && meas_rail == RAIL_W'(i) && meas_volt > wmax_r[i]) begin
                    wmax_nxt[i] = meas_volt;                             // R12
                end
                if (tick) begin
                    if (wms_r[i] == WIN_W'(WIN_MS - 1)) begin
                        won_nxt[i]   = 1'b0;
                        peak_nxt[i]  = wmax_nxt[i];                      // R12
                        dirty_nxt[i] = 1'b1;                             // R15
                    end else begin
                        wms_nxt[i] = wms_r[i] + 1'b1;
                    end
                end
            end else if (meas_valid && meas_rail == RAIL_W'(i) && meas_volt > peak_r[i]) begin
                won_nxt[i]  = 1'b1;                                      // R12
                wmax_nxt[i] = meas_volt;
                wms_nxt[i]  = '0;
            end
        end
        fcnt_nxt     = fcnt_r + FC_W'(fault_take);                       // R10
        clk_pend_nxt = clk_pend_nxt || commit_cmd;                       // R2
        if (clr_resets_cmd) begin
            rcnt_nxt     = '0;                                           // R11
            rst_pend_nxt = 1'b1;
        end else if (take_restore) begin
            rcnt_nxt     = nvm_restore_resets + 32'h1;                   // R11
            rst_pend_nxt = 1'b1;
        end
        if (bo_en_r && vcc_low && !vcc_low_r) begin
            dump_nxt     = 1'b1;                                         // R16
            clk_pend_nxt = 1'b1;
            rst_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r       <= ST_IDLE;
            bo_en_r    <= 1'b0;                                          // R13
            vcc_low_r  <= 1'b0;
            dump_r     <= 1'b0;
            clk_pend_r <= 1'b0;
            rst_pend_r <= 1'b0;
            rcnt_r     <= '0;
            peak_r     <= '{default: '0};
            wmax_r     <= '{default: '0};
            wms_r      <= '{default: '0};
            won_r      <= '0;
            dirty_r    <= '0;
            fcnt_r     <= '0;
            flush_r    <= '0;
            out_r      <= '0;
            outv_r     <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            bo_en_r    <= misc_bo_en;                                    // R13
            vcc_low_r  <= vcc_low;                                       // R14
            dump_r     <= dump_nxt;
            clk_pend_r <= clk_pend_nxt;
            rst_pend_r <= rst_pend_nxt;
            rcnt_r     <= rcnt_nxt;
            peak_r     <= peak_nxt;
            wmax_r     <= wmax_nxt;
            wms_r      <= wms_nxt;
            won_r      <= won_nxt;
            dirty_r    <= dirty_nxt;
            fcnt_r     <= fcnt_nxt;
            flush_r    <= flush_nxt;
            out_r      <= out_nxt;
            outv_r     <= outv_nxt;
        end
    end

    // ******************************
    // Fault store and readback
    // ******************************
    // Full store keeps the oldest faults; later ones are dropped
    always_ff @(posedge core_clk) begin
        if (fault_take) begin
            fbuf_r[fcnt_r[IDX_W-1:0]] <= '{kind: REC_FAULT, rail: fault_in.rail, ftype: fault_in.ftype,
                                           volt: fault_in.volt, time_v: time_r};  // R8 R9
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_r <= '0;
        end else begin
            rd_r <= (FC_W'(rd_idx) < fcnt_r) ? fbuf_r[rd_idx] : '0;      // R10
        end
    end

    assign rt_time        = time_r;
    assign reset_count    = rcnt_r;
    assign brownout_flag  = vcc_low_r;
    assign rd_rec         = rd_r;
    assign fault_count    = fcnt_r;
    assign flash_wr_valid = outv_r;
    assign flash_wr_rec   = out_r;

    // ******************************
    // Checks
    // ******************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    chk_day_rollover: assert property (tick && !rt_wr_valid && !(take_restore && bo_en_r)       // R19
        && time_r.ms == MS_PER_DAY - 32'h1 |=> time_r.ms == '0 && time_r.days == $past(time_r.days) + 32'h1)
        else $error("day rollover wrong");
    chk_host_write: assert property (rt_wr_valid |=> time_r == $past(rt_wr_time))   // R3
        else $error("host clock write lost");
    chk_boot_hold: assert property (!boot_done && !rt_wr_valid && !take_restore     // R6
        |=> $stable(time_r))
        else $error("clock moved during boot");
    chk_flash_gate: assert property ($rose(outv_r) |-> $past(go))                  // R17
        else $error("flash write in brownout mode");
    chk_commit_clock: assert property (commit_cmd ##1 (st_r == ST_IDLE && go)       // R2
        |=> outv_r && out_r.kind == REC_CLOCK)
        else $error("commit did not write clock");
    chk_fault_stamp: assert property (fault_take |=> fbuf_r[$past(fcnt_r[IDX_W-1:0])].time_v  // R8
        == $past(time_r) && fbuf_r[$past(fcnt_r[IDX_W-1:0])].rail == $past(fault_in.rail))
        else $error("fault record stamp wrong");
    chk_reset_clear: assert property (clr_resets_cmd |=> rcnt_r == '0 && rst_pend_r) // R11
        else $error("reset count not cleared");
    chk_brownout_dump: assert property (bo_en_r && vcc_low && !vcc_low_r             // R16
        |=> dump_r && clk_pend_r && brownout_flag)
        else $error("brownout did not start dump");
    chk_peak_commit: assert property ($fell(won_r[0]) |-> dirty_r[0]                 // R12
        && peak_r[0] == $past(wmax_nxt[0]))
        else $error("peak window result wrong");

    cov_clock_write: cover property (commit_cmd ##[1:8] (outv_r && out_r.kind == REC_CLOCK));
    cov_dump_fault:  cover property (dump_r && outv_r && out_r.kind == REC_FAULT);
    cov_peak_write:  cover property (outv_r && out_r.kind == REC_PEAK);

endmodule // rtc_fault_logger

// *** sim/flash_model.sv ***
// Purpose: Behavioural flash store that takes records from the logger
// Assumes: One record is taken per valid and ready edge
// Notes:   Contents survive arst_n, as real flash would
`timescale 1ns/1ps
module flash_model
    import rtc_log_pkg::*;
(
    input  wire logic       core_clk, // System clock
    input  wire logic       arst_n,   // Async reset, active low
    input  wire logic       slow,     // Stall at random when high
    input  wire logic       wr_valid, // Record offered
    input  wire flash_rec_s wr_rec,   // Offered record
    output logic            wr_ready  // Record taken this edge
);
    int         nwr = 0;
    flash_rec_s last_rec [4];

    // Random stalls show whether the logger holds its record steady
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ready <= 1'b0;
        end else begin
            wr_ready <= slow ? 1'($urandom % 2) : 1'b1;
            if (wr_valid && wr_ready) begin
                nwr                   <= nwr + 1;
                last_rec[wr_rec.kind] <= wr_rec;
            end
        end
    end
endmodule // flash_model

// *** sim/rtc_fault_logger_tb.sv ***
// Purpose: Self-checking bench for the run-time clock and fault logger
// Assumes: Prescaler of 4 cycles per ms and a 5 ms peak window
// Notes:   No calendar conversion is done here; the logger only sees counts
`timescale 1ns/1ps
module rtc_fault_logger_tb;
    import rtc_log_pkg::*;
    // ******************************
    // Signals
    // ******************************
    localparam int unsigned CMS = 4;
    logic        core_clk, arst_n, boot_done, rt_wr_valid, commit_cmd, clr_resets_cmd;
    logic        misc_bo_en, nvm_restore_valid, fault_valid, meas_valid, flash_wr_ready, slow;
    rt_time_s    rt_wr_time, nvm_restore_time, rt_time, t;
    fault_in_s   fault_in;
    flash_rec_s  rd_rec, flash_wr_rec, exp_rec [3];
    logic [31:0] nvm_restore_resets, reset_count, rv;
    logic [3:0]  meas_rail, rd_idx, fault_count;
    logic [11:0] meas_volt, vcc_mv, vmax;
    logic        brownout_flag, flash_wr_valid;
    int          errors = 0, num_checks = 0, n0;

    rtc_fault_logger #(.CYC_MS(CMS), .WIN_MS(5)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .boot_done(boot_done), .rt_wr_valid(rt_wr_valid), .rt_wr_time(rt_wr_time),
        .commit_cmd(commit_cmd), .clr_resets_cmd(clr_resets_cmd), .misc_bo_en(misc_bo_en),
        .nvm_restore_valid(nvm_restore_valid), .nvm_restore_time(nvm_restore_time),
        .nvm_restore_resets(nvm_restore_resets), .fault_valid(fault_valid), .fault_in(fault_in),
        .meas_valid(meas_valid), .meas_rail(meas_rail), .meas_volt(meas_volt), .vcc_mv(vcc_mv),
        .rd_idx(rd_idx), .flash_wr_ready(flash_wr_ready), .rt_time(rt_time),
        .reset_count(reset_count), .brownout_flag(brownout_flag), .rd_rec(rd_rec),
        .fault_count(fault_count), .flash_wr_valid(flash_wr_valid), .flash_wr_rec(flash_wr_rec));
    flash_model fm (.core_clk(core_clk), .arst_n(arst_n), .slow(slow), .wr_valid(flash_wr_valid),
        .wr_rec(flash_wr_rec), .wr_ready(flash_wr_ready));

    // ******************************
    // Helpers
    // ******************************
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic flash_rec_s mk_fault(input fault_in_s f, input rt_time_s tm);
        return '{kind: REC_FAULT, rail: f.rail, ftype: f.ftype, volt: f.volt, time_v: tm};
    endfunction
    // Host side writes day and ms counts directly, with no calendar conversion
    task automatic set_time(input rt_time_s tm);
        rt_wr_time  <= tm;
        rt_wr_valid <= 1'b1;
        tick(1);
        rt_wr_valid <= 1'b0;
        tick(1);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        tick(20);
        arst_n <= 1'b1;
        tick(2);
    endtask
    task automatic restore(input rt_time_s tm, input logic [31:0] r);
        nvm_restore_time   <= tm;
        nvm_restore_resets <= r;
        nvm_restore_valid  <= 1'b1;
        tick(1);
        nvm_restore_valid <= 1'b0;
        tick(3);
        #1;
    endtask

    // ******************************
    // Clock, watchdog and stimulus
    // ******************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        tick(30000);
        errors++;
        wrap_up();
    end
    initial begin
        {arst_n, boot_done, rt_wr_valid, commit_cmd, clr_resets_cmd, misc_bo_en} = '0;
        {nvm_restore_valid, fault_valid, meas_valid, slow, rd_idx, meas_rail, meas_volt} = '0;
        {rt_wr_time, nvm_restore_time, nvm_restore_resets, fault_in} = '0;
        vcc_mv = 12'hCE4;
        void'($urandom(32'hc351));
        do_reset();
        #1;
        chk({rt_time, reset_count, fault_count}, '0);
        rv = $urandom % 1000;
        restore('{days: 32'h0000_0007, ms: 32'h0000_1234}, rv);
        chk(rt_time, '0);
        chk(reset_count, rv + 1);
        tick(1);
        // Frozen before boot, then counting from a written value
        t = '{days: $urandom, ms: $urandom % 32'h0500_0000};
        set_time(t);
        tick(20);
        #1;
        chk(rt_time, t);
        tick(1);
        boot_done <= 1'b1;
        set_time(t);
        tick(CMS * 10);
        #1;
        chk((rt_time.ms - t.ms) inside {9, 10}, 1'b1);
        chk(rt_time.days, t.days);
        tick(1);
        set_time('{days: t.days, ms: MS_PER_DAY - 32'h1});
        tick(8);
        #1;
        chk({rt_time.days, 31'(rt_time.ms >> 1)}, {t.days + 32'h1, 31'h0});
        // Faults stamped with a frozen clock
        tick(1);
        boot_done <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            t = '{days: $urandom, ms: $urandom % MS_PER_DAY};
            set_time(t);
            fault_in    <= '{rail: 4'($urandom % 12), ftype: 4'($urandom), volt: 12'($urandom)};
            fault_valid <= 1'b1;
            tick(1);
            fault_valid <= 1'b0;
            exp_rec[i] = mk_fault(fault_in, t);
        end
        tick(40);
        #1;
        chk(fault_count, 4'h3);
        chk(fm.last_rec[REC_FAULT], exp_rec[2]);
        for (int i = 0; i < 4; i++) begin
            tick(1);
            rd_idx <= 4'(i);
            tick(2);
            #1;
            chk(rd_rec, (i < 3) ? exp_rec[i] : '0);
        end
        tick(1);
        commit_cmd <= 1'b1;
        tick(1);
        commit_cmd <= 1'b0;
        tick(30);
        #1;
        chk(fm.last_rec[REC_CLOCK].time_v, t);
        tick(1);
        clr_resets_cmd <= 1'b1;
        tick(1);
        clr_resets_cmd <= 1'b0;
        tick(30);
        #1;
        chk({reset_count, fm.last_rec[REC_RESETS].time_v.ms}, '0);
        // Peak window keeps only its maximum
        tick(1);
        boot_done  <= 1'b1;
        meas_rail  <= 4'h0;
        meas_valid <= 1'b1;
        vmax = '0;
        for (int i = 0; i < 4; i++) begin
            meas_volt <= 12'($urandom % 3000 + 1);
            tick(1);
            if (meas_volt > vmax) vmax = meas_volt;
        end
        meas_valid <= 1'b0;
        tick(80);
        #1;
        chk({fm.last_rec[REC_PEAK].rail, fm.last_rec[REC_PEAK].volt}, {4'h0, vmax});
        n0 = fm.nwr;
        tick(1);
        meas_volt  <= vmax;
        meas_valid <= 1'b1;
        tick(1);
        meas_valid <= 1'b0;
        tick(80);
        #1;
        chk(fm.nwr, n0);
        // Brownout mode: persistent clock, held log, dump on supply loss
        tick(1);
        boot_done  <= 1'b0;
        misc_bo_en <= 1'b1;
        do_reset();
        t  = '{days: $urandom, ms: $urandom % MS_PER_DAY};
        rv = $urandom % 1000;
        restore(t, rv);
        chk(rt_time, t);
        n0 = fm.nwr;
        tick(1);
        fault_in    <= '{rail: 4'hB, ftype: 4'($urandom), volt: 12'($urandom)};
        fault_valid <= 1'b1;
        tick(1);
        fault_valid <= 1'b0;
        commit_cmd  <= 1'b1;
        exp_rec[0] = mk_fault(fault_in, t);
        tick(1);
        commit_cmd <= 1'b0;
        tick(40);
        #1;
        chk({fm.nwr, 1'(brownout_flag)}, {n0, 1'b0});
        tick(1);
        vcc_mv <= 12'hB53;
        slow   <= 1'b1;
        tick(3);
        #1;
        chk(brownout_flag, 1'b1);
        tick(300);
        #1;
        chk(fm.last_rec[REC_CLOCK].time_v, t);
        chk(fm.last_rec[REC_FAULT], exp_rec[0]);
        chk(fm.last_rec[REC_RESETS].time_v.ms, rv + 1);
        wrap_up();
    end
endmodule // rtc_fault_logger_tb
